/* design/grv_rail_ctrl.sv */
/*
  Digital control of the graphics-core step-down rail: shared code-pin
  capture under the latch pins, software override, setpoint ramp, switching
  mode selection, standby-exit mode copy, discharge and overcurrent fault.
  Assumes the SPI slave presents a one-cycle byte register port on this
  clock, and that the analog loop consumes the drive and setpoint outputs.
*/
// Summary of operation
// - Voltage code becomes setpoint 0.3 V to 1.2 V, 12.5 mV per step.
// - Code pins sampled every cycle of the grant into storage the host cannot access.
// - Shared code pins taken only while this rail's latch pin grants it.
// - New codes ramp the setpoint one 12.5 mV step per 520 ns, under 25 mV per microsecond.
// - Host selects PFM, pulse skipping or PWM over SPI.
// - Output discharge path active whenever the rail is off.
// - Overcurrent limits cycle by cycle and raises rail fault and interrupt.
// - State field 2:0 decodes 4 off, 5 PFM, 6 skip, 7 PWM.
// - Standby exit copies exit field 4 to 7 into state; 0 to 3 ignored.
// - Voltage-code register bits 6:0 hold a software code, pin encoding.
// - Bit 7 selects code source: 0 pins, 1 software code.
// - Exit field sits in control bits 5:3; bits 7:6 reserved.
`timescale 1ns/100ps
module grv_rail_ctrl (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [6:0] voltage_code_pins_i,
  input wire logic [1:0] voltage_code_enable_pins_i,
  input wire logic standby_exit_pin_i,
  input wire logic overcurrent_i,
  output grv_pkg::grv_drive_t drive_o,
  output logic [13:0] setpoint_o,
  output logic [6:0] setpoint_code_o,
  output logic ramping_o,
  output logic current_limit_o,
  output logic graphics_rail_fault_o,
  output logic regulator_fault_interrupt_o
);
  import grv_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] vcode;
    logic [7:0] ctrl;
    logic [6:0] vid_hold;
    logic exit_seen;
    grv_rail_t rail;
    grv_drive_t drive;
    logic climit;
    logic fault;
    logic irq;
    logic [7:0] rdata;
    logic rvalid;
    logic [13:0] sp;
    logic [6:0] sp_code;
    logic ramping;
  } grv_ctrl_st_t;

  grv_ctrl_st_t st_r;
  grv_ctrl_st_t st_nxt;

  grv_pins_t pins_raw;
  grv_pins_t pins_s;
  logic [6:0] target;
  logic [6:0] ramp_code;
  logic [13:0] ramp_sp;
  logic ramp_busy;
  logic [2:0] exit_mode;
  logic [2:0] state_field;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  always_comb begin
    pins_raw.voltage_code_pins = voltage_code_pins_i;
    pins_raw.latch = voltage_code_enable_pins_i;
    pins_raw.standby_exit = standby_exit_pin_i;
    pins_raw.overcurrent = overcurrent_i;
  end

  grv_sync u_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .pins_i(pins_raw),
    .pins_o(pins_s)
  );

  // ****************************************************************
  // code source and ramp
  // ****************************************************************
  // override bit picks the software code, else the latched pin code
  assign target = st_r.vcode[GRV_OVERRIDE_BIT] ? st_r.vcode[GRV_SWCODE_MSB:0] : st_r.vid_hold;

  grv_ramp u_ramp (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .target_i(target),
    .code_o(ramp_code),
    .setpoint_o(ramp_sp),
    .ramping_o(ramp_busy)
  );

  assign exit_mode = st_r.ctrl[GRV_EXIT_MSB:GRV_EXIT_LSB];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    state_field = '0;

    // capture the shared code only while our latch pin grants it
    if (pins_s.latch[GRV_LATCH_BIT]) begin
      st_nxt.vid_hold = pins_s.voltage_code_pins;
    end

    // register writes; reserved control bits stay zero
    if (reg_wr_i) begin
      if (reg_addr_i == GRV_VCODE_ADDR) begin
        st_nxt.vcode = reg_wdata_i;
      end else if (reg_addr_i == GRV_CTRL_ADDR) begin
        st_nxt.ctrl = reg_wdata_i & GRV_CTRL_WMASK;
      end
    end

    // standby exit acts on the assertion edge so later host writes stick;
    // it wins over a host write to the state field in the same cycle
    st_nxt.exit_seen = pins_s.standby_exit;
    if (pins_s.standby_exit && !st_r.exit_seen && exit_mode[2]) begin
      st_nxt.ctrl[GRV_STATE_MSB:GRV_STATE_LSB] = exit_mode;
    end

    // register reads answer one cycle later; unmapped addresses read zero
    st_nxt.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      if (reg_addr_i == GRV_VCODE_ADDR) begin
        st_nxt.rdata = st_r.vcode;
      end else if (reg_addr_i == GRV_CTRL_ADDR) begin
        st_nxt.rdata = st_r.ctrl;
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end

    // operating state follows the field; reserved codes keep the last state
    state_field = st_nxt.ctrl[GRV_STATE_MSB:GRV_STATE_LSB];
    case (state_field)
      GRV_MODE_OFF: st_nxt.rail = GRV_ST_OFF;
      GRV_MODE_PFM: st_nxt.rail = GRV_ST_PFM;
      GRV_MODE_SKIP: st_nxt.rail = GRV_ST_SKIP;
      GRV_MODE_PWM: st_nxt.rail = GRV_ST_PWM;
      default: st_nxt.rail = st_r.rail;
    endcase

    st_nxt.drive = '0;
    case (st_nxt.rail)
      GRV_ST_OFF: begin
        st_nxt.drive.discharge = 1'b1;
      end
      GRV_ST_PFM: begin
        st_nxt.drive.rail_on = 1'b1;
        st_nxt.drive.pfm = 1'b1;
      end
      GRV_ST_SKIP: begin
        st_nxt.drive.rail_on = 1'b1;
        st_nxt.drive.skip = 1'b1;
      end
      default: begin
        st_nxt.drive.rail_on = 1'b1;
        st_nxt.drive.pwm = 1'b1;
      end
    endcase

    // overcurrent: limit the present cycle and flag the fault upward;
    // fault is a level that clears when the comparator releases
    st_nxt.climit = pins_s.overcurrent && st_nxt.drive.rail_on;
    st_nxt.fault = pins_s.overcurrent;
    st_nxt.irq = st_r.fault;

    st_nxt.sp = ramp_sp;
    st_nxt.sp_code = ramp_code;
    st_nxt.ramping = ramp_busy;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '{vcode: GRV_VCODE_RST, ctrl: GRV_CTRL_RST, vid_hold: GRV_HOLD_RST,
                exit_seen: 1'b0, rail: GRV_ST_OFF, drive: 5'b00001, climit: 1'b0,
                fault: 1'b0, irq: 1'b0, rdata: 8'h00, rvalid: 1'b0,
                sp: GRV_SP_BASE, sp_code: GRV_HOLD_RST, ramping: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs, all from flops
  // ****************************************************************
  assign reg_rdata_o = st_r.rdata;
  assign reg_rvalid_o = st_r.rvalid;
  assign drive_o = st_r.drive;
  assign setpoint_o = st_r.sp;
  assign setpoint_code_o = st_r.sp_code;
  assign ramping_o = st_r.ramping;
  assign current_limit_o = st_r.climit;
  assign graphics_rail_fault_o = st_r.fault;
  assign regulator_fault_interrupt_o = st_r.irq;

endmodule

/* design/grv_pkg.sv */
/*
  Shared constants and types for the graphics-core rail control block:
  register map, field layout, reset values, operating states and ramp timing.
  Assumes a single 25 MHz core clock and a register port fed by the SPI slave.
*/
package grv_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int GRV_CLK_PERIOD_NS = 40;
  localparam int GRV_STEP_UV = 12500;
  localparam int GRV_SLEW_MV_PER_US = 25;
  // one code step per 500 ns keeps the output at the fixed slew
  localparam int GRV_STEP_TIME_NS = GRV_STEP_UV / GRV_SLEW_MV_PER_US;
  // least time per step, so round up: the slew is never exceeded
  localparam int GRV_STEP_CYCLES = (GRV_STEP_TIME_NS + GRV_CLK_PERIOD_NS - 1) / GRV_CLK_PERIOD_NS;
  localparam logic [3:0] GRV_STEP_LAST = 4'(GRV_STEP_CYCLES - 1);

  // ****************************************************************
  // setpoint scale, units of 0.1 mV
  // ****************************************************************
  localparam logic [13:0] GRV_SP_BASE = 14'h0BB8;
  localparam logic [13:0] GRV_SP_STEP = 14'h007D;
  localparam logic [13:0] GRV_SP_MAX = 14'h2EE0;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] GRV_VCODE_ADDR = 8'h33;
  localparam logic [7:0] GRV_CTRL_ADDR = 8'h36;
  localparam logic [7:0] GRV_VCODE_RST = 8'h7F;
  localparam logic [7:0] GRV_CTRL_RST = 8'h04;
  localparam logic [7:0] GRV_CTRL_WMASK = 8'h3F;

  localparam int GRV_STATE_LSB = 0;
  localparam int GRV_STATE_MSB = 2;
  localparam int GRV_EXIT_LSB = 3;
  localparam int GRV_EXIT_MSB = 5;
  localparam int GRV_SWCODE_MSB = 6;
  localparam int GRV_OVERRIDE_BIT = 7;
  // which of the two latch pins grants this rail the shared code pins
  localparam int GRV_LATCH_BIT = 0;
  localparam logic [6:0] GRV_HOLD_RST = 7'h00;

  localparam logic [2:0] GRV_MODE_OFF = 3'h4;
  localparam logic [2:0] GRV_MODE_PFM = 3'h5;
  localparam logic [2:0] GRV_MODE_SKIP = 3'h6;
  localparam logic [2:0] GRV_MODE_PWM = 3'h7;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {GRV_ST_OFF, GRV_ST_PFM, GRV_ST_SKIP, GRV_ST_PWM} grv_rail_t;
  typedef enum logic [1:0] {GRV_RAMP_HOLD, GRV_RAMP_UP, GRV_RAMP_DOWN} grv_ramp_t;

  typedef struct packed {
    logic [6:0] voltage_code_pins;
    logic [1:0] latch;
    logic standby_exit;
    logic overcurrent;
  } grv_pins_t;

  typedef struct packed {
    logic rail_on;
    logic pfm;
    logic skip;
    logic pwm;
    logic discharge;
  } grv_drive_t;

endpackage

/* design/grv_sync.sv */
/*
  Two-flop synchroniser for every asynchronous pin of the rail block.
  Assumes pins are quasi-static compared with the 40 ns clock; a multi-bit
  code may be caught mid-change for one cycle and is corrected the next.
*/
`timescale 1ns/100ps
module grv_sync (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire grv_pkg::grv_pins_t pins_i,
  output grv_pkg::grv_pins_t pins_o
);
  import grv_pkg::*;

  typedef struct packed {
    grv_pins_t meta;
    grv_pins_t stable;
  } grv_sync_st_t;

  grv_sync_st_t st_r;
  grv_sync_st_t st_nxt;

  // first stage is read only by the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pins_i;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_o = st_r.stable;

endmodule

/* design/grv_ramp.sv */
/*
  Setpoint slew limiter: moves the active code one step toward the target
  per step interval and converts the code into a setpoint in 0.1 mV units.
  Assumes the target comes from logic on the same clock.
*/
`timescale 1ns/100ps
module grv_ramp (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [6:0] target_i,
  output logic [6:0] code_o,
  output logic [13:0] setpoint_o,
  output logic ramping_o
);
  import grv_pkg::*;

  typedef struct packed {
    grv_ramp_t st;
    logic [3:0] tick;
    logic [6:0] code;
    logic [13:0] sp;
  } grv_ramp_st_t;

  grv_ramp_st_t st_r;
  grv_ramp_st_t st_nxt;
  logic [14:0] sp_raw;

  always_comb begin
    st_nxt = st_r;
    sp_raw = '0;
    case (st_r.st)
      GRV_RAMP_HOLD: begin
        st_nxt.tick = '0;
        if (target_i > st_r.code) begin
          st_nxt.st = GRV_RAMP_UP;
        end else if (target_i < st_r.code) begin
          st_nxt.st = GRV_RAMP_DOWN;
        end
      end
      default: begin
        // one step per interval, never a jump to the new code
        if (st_r.tick == GRV_STEP_LAST) begin
          st_nxt.tick = '0;
          if (st_r.st == GRV_RAMP_UP && target_i > st_r.code) begin
            st_nxt.code = st_r.code + 7'h01;
          end else if (st_r.st == GRV_RAMP_DOWN && target_i < st_r.code) begin
            st_nxt.code = st_r.code - 7'h01;
          end
          if (target_i == st_nxt.code) begin
            st_nxt.st = GRV_RAMP_HOLD;
          end else if (target_i > st_nxt.code) begin
            st_nxt.st = GRV_RAMP_UP;
          end else begin
            st_nxt.st = GRV_RAMP_DOWN;
          end
        end else begin
          st_nxt.tick = st_r.tick + 4'h1;
        end
      end
    endcase
    // code to setpoint, clamped to the top of the range
    // 15 bits: the top codes overflow 14 bits before the clamp
    sp_raw = 15'(GRV_SP_BASE) + 15'(st_nxt.code) * 15'(GRV_SP_STEP);
    st_nxt.sp = (sp_raw > 15'(GRV_SP_MAX)) ? GRV_SP_MAX : sp_raw[13:0];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '{st: GRV_RAMP_HOLD, tick: 4'h0, code: GRV_HOLD_RST, sp: GRV_SP_BASE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign code_o = st_r.code;
  assign setpoint_o = st_r.sp;
  assign ramping_o = (st_r.st != GRV_RAMP_HOLD);

endmodule

/* dv/grv_rail_ctrl_sva.sv */
/*
  Port checks for grv_rail_ctrl.
  Assumes a bind from the bench top file.
*/
`timescale 1ns/100ps
module grv_rail_ctrl_sva (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic reg_rd_i,
  input wire logic reg_rvalid_o,
  input wire logic overcurrent_i,
  input wire grv_pkg::grv_drive_t drive_o,
  input wire logic [13:0] setpoint_o,
  input wire logic [6:0] setpoint_code_o,
  input wire logic graphics_rail_fault_o,
  input wire logic regulator_fault_interrupt_o
);
  import grv_pkg::*;
  logic [3:0] gap_r;
  // ****************
  // step spacing
  // ****************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_r <= 4'hF;
    end else if ($changed(setpoint_code_o)) begin
      gap_r <= 4'h0;
    end else if (gap_r != 4'hF) begin
      gap_r <= gap_r + 4'h1;
    end
  end
  function automatic logic [13:0] spx(logic [6:0] c);
    return (c >= 7'h48) ? GRV_SP_MAX : GRV_SP_BASE + 14'(c) * GRV_SP_STEP;
  endfunction
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_dis; drive_o.rail_on != drive_o.discharge; endproperty
  a_dis: assert property (p_dis) else $error("discharge wrong");
  property p_mode; drive_o.rail_on == (drive_o.pfm | drive_o.skip | drive_o.pwm); endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_sp; $stable(setpoint_code_o) |-> setpoint_o == spx(setpoint_code_o); endproperty
  a_sp: assert property (p_sp) else $error("setpoint scale wrong");
  property p_step; $changed(setpoint_code_o) |-> 7'(setpoint_code_o - $past(setpoint_code_o) + 7'h01) <= 7'h02; endproperty
  a_step: assert property (p_step) else $error("code jumped");
  property p_gap; $changed(setpoint_code_o) |-> gap_r >= GRV_STEP_LAST; endproperty
  a_gap: assert property (p_gap) else $error("ramp too fast");
  property p_irq; regulator_fault_interrupt_o == $past(graphics_rail_fault_o); endproperty
  a_irq: assert property (p_irq) else $error("interrupt not following fault");
  property p_flt; $rose(overcurrent_i) |-> ##[2:4] graphics_rail_fault_o; endproperty
  a_flt: assert property (p_flt) else $error("fault late");
  property p_rv; reg_rvalid_o == $past(reg_rd_i); endproperty
  a_rv: assert property (p_rv) else $error("read answer timing");
endmodule

/* dv/grv_host_model.sv */
/*
  Processor side of the code pins.
  Assumes requests from the bench; pins move just after an edge.
*/
`timescale 1ns/100ps
module grv_host_model (
  input wire logic core_clk_i,
  input wire grv_pkg::grv_pins_t req_i,
  output grv_pkg::grv_pins_t pins_o
);
  import grv_pkg::*;
  always_ff @(posedge core_clk_i) begin
    pins_o.latch <= req_i.latch;
    pins_o.standby_exit <= req_i.standby_exit;
    pins_o.overcurrent <= req_i.overcurrent;
    // other rail owns the pins: they carry a code meant for it
    pins_o.voltage_code_pins <= req_i.latch[0] ? req_i.voltage_code_pins : ~req_i.voltage_code_pins;
  end
endmodule

/* dv/grv_rail_ctrl_tb.sv */
/*
  Self-checking bench for grv_rail_ctrl with a reference model.
  Assumes grv_host_model drives the pins and the checker is bound here.
*/
`timescale 1ns/100ps
module grv_rail_ctrl_tb;
  import grv_pkg::*;
  logic core_clk_i, resetn_i, wr, rd, rvalid, ramping, limit, fault, irq;
  logic [7:0] addr, wdata, rdata;
  logic [13:0] sp;
  logic [6:0] code;
  grv_pins_t req, pins;
  grv_drive_t drive;
  int errors, tests_run, cycles, ctrl_m, vcode_m, hold_m;
  grv_rail_ctrl i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .voltage_code_pins_i(pins.voltage_code_pins), .voltage_code_enable_pins_i(pins.latch),
    .standby_exit_pin_i(pins.standby_exit), .overcurrent_i(pins.overcurrent), .drive_o(drive),
    .setpoint_o(sp), .setpoint_code_o(code), .ramping_o(ramping), .current_limit_o(limit),
    .graphics_rail_fault_o(fault), .regulator_fault_interrupt_o(irq));
  grv_host_model i_host (.core_clk_i(core_clk_i), .req_i(req), .pins_o(pins));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (e !== g) begin
      errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic results;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [4:0] dx(int m);
    return {m != 4, m == 5, m == 6, m == 7, m == 4};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    if (a == 8'h33) vcode_m = d;
    if (a == 8'h36) ctrl_m = d & 8'h3F;
  endtask
  task automatic rdchk(input logic [7:0] a, input int e);
    int n;
    n = 0;
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    while (rvalid !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    chk(1, rvalid);
    chk(e, rdata);
  endtask
  task automatic settle;
    int n, t, d, s;
    t = (vcode_m >= 128) ? vcode_m - 128 : hold_m;
    d = (t > code) ? t - code : code - t;
    s = 3000 + t * 125;
    n = 0;
    tick(6);
    if (d > 0) chk(1, ramping);
    while ((ramping !== 1'b0 || code !== 7'(t)) && n < 2000) begin
      tick(1);
      n++;
    end
    chk(t, code);
    chk((s > 12000) ? 12000 : s, sp);
    chk(1, n + 19 >= d * 13);
    chk(0, ramping);
  endtask
  initial begin
    {resetn_i, addr, wdata, wr, rd, errors, tests_run, cycles} = '0;
    req = '0;
    ctrl_m = 4;
    vcode_m = 'h7F;
    hold_m = 0;
    void'($urandom(32'hF7855615));
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rdchk(8'h33, 'h7F);
    rdchk(8'h36, 'h04);
    rdchk(8'h34, 0);
    chk(dx(4), drive);
    for (int m = 4; m < 8; m++) begin
      wreg(8'h36, 8'(m | (($urandom % 8) << 3) | 'hC0));
      rdchk(8'h36, ctrl_m);
      chk(dx(m), drive);
    end
    for (int i = 0; i < 3; i++) begin
      wreg(8'h33, (i == 1) ? 8'hFF : 8'h80 | 8'($urandom % 128));
      settle();
    end
    // pins granted, then handed to the other rail
    for (int i = 0; i < 2; i++) begin
      hold_m = (i == 0) ? $urandom % 128 : hold_m;
      @(posedge core_clk_i);
      req.latch <= (i == 0) ? 2'b01 : 2'b10;
      req.voltage_code_pins <= 7'(hold_m);
      wreg(8'h33, 8'h05);
      settle();
    end
    for (int x = 0; x < 8; x++) begin
      wreg(8'h36, 8'((x << 3) | 4));
      req.standby_exit <= 1'b1;
      tick(6);
      @(posedge core_clk_i);
      req.standby_exit <= 1'b0;
      tick(6);
      if (x >= 4) ctrl_m = (x << 3) | x;
      rdchk(8'h36, ctrl_m);
      chk(dx(ctrl_m & 7), drive);
    end
    @(posedge core_clk_i);
    req.overcurrent <= 1'b1;
    tick(8);
    chk(3'h7, {fault, irq, limit});
    @(posedge core_clk_i);
    req.overcurrent <= 1'b0;
    tick(8);
    chk(3'h0, {fault, irq, limit});
    results();
  end
endmodule
bind grv_rail_ctrl grv_rail_ctrl_sva i_sva (.core_clk_i, .resetn_i, .reg_rd_i, .reg_rvalid_o, .overcurrent_i,
  .drive_o, .setpoint_o, .setpoint_code_o, .graphics_rail_fault_o, .regulator_fault_interrupt_o);
